// ---- src/gaea_top.sv ----
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
// What this block does
// - Take-control runs only while the board is active controller.
// - Take-control forces all other instruments idle so the board controls the bus.
// - As active and system controller, take-control pulses IFC.
// - As active non-system controller, assert ATN then send untalk and unlisten.
// - Arming mask is a 16-bit word; bits 7 to 0 each enable one condition, bits 15 to 9 are dropped.
// - Address-change bit arms every role-change condition at once.
// - Bit 7 arms the flag on becoming active controller.
// - Bit 6 arms the flag on passing control away.
// - Bit 5 arms the flag on a received bus trigger as peripheral.
// - Bit 4 arms the flag when the internal service request bit sets.
// - Bit 3 arms the flag on a received bus clear as peripheral.
// - Bit 2 arms the flag when addressed to listen as peripheral.
// - Bit 1 arms the flag when addressed to talk as peripheral.
// - Bit 0 arms the flag when unaddressed as peripheral.
// - Role-change conditions count only when the address-change status bit is set.
// - Flag generation is off after reset until emulation is enabled.
module gaea_top (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic active_ctrl,
  input wire logic system_ctrl,
  input wire logic control_gained,
  input wire logic listen_selected,
  input wire logic output_role_assigned,
  input wire logic trigger_received,
  input wire logic clear_received,
  input wire logic internal_service_request,
  input wire logic address_role_changed,
  input wire logic cmd_ready,
  output logic ifc_out,
  output logic atn_out,
  output logic cmd_valid,
  output logic [7:0] cmd_byte,
  output logic event_flag,
  output logic irq
);
  import gaea_pkg::*;

  // ----------------------------------------------------------------
  // Overview
  // ----------------------------------------------------------------
  // The host reaches five registers over a plain strobe port.
  // A write of the take bit while the board is active controller starts
  // one of two sequences on the instrument bus.
  // As system controller it is a timed interface clear pulse.
  // Otherwise attention rises and untalk and unlisten follow in order.
  // Bus and role inputs come from another domain and pass two flops.
  // A third stage keeps the previous synced value for edge detection.
  // Each armed edge sets a sticky event bit that is cleared by a one.
  // A set that falls in the same cycle as its clear wins.
  // Attention stays asserted after the commands, as the board keeps control.
  // The interface clear length is fixed by a package constant.

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // The third stage only delays the second one; it never sees a raw pin,
  // so edges are taken between two settled samples.
  // An edge is therefore seen two clocks after the pin changes.
  localparam int NIN = 9;
  logic [NIN-1:0] raw_in;
  logic [NIN-1:0] s1_r;
  logic [NIN-1:0] s2_r;
  logic [NIN-1:0] s3_r;

  assign raw_in = {active_ctrl, system_ctrl, control_gained, listen_selected,
                   output_role_assigned, trigger_received, clear_received,
                   internal_service_request, address_role_changed};

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end
    else
    begin
      s1_r <= raw_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  logic act_s, sys_s, gain_s, lsn_s, tlk_s, trg_s, clr_s, svc_s, chg_s;
  assign {act_s, sys_s, gain_s, lsn_s, tlk_s, trg_s, clr_s, svc_s, chg_s} = s2_r;

  logic act_p, gain_p, lsn_p, tlk_p, trg_p, clr_p, svc_p;
  assign act_p = s3_r[8];
  assign gain_p = s3_r[6];
  assign lsn_p = s3_r[5];
  assign tlk_p = s3_r[4];
  assign trg_p = s3_r[3];
  assign clr_p = s3_r[2];
  assign svc_p = s3_r[1];

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [15:0] arm_r;
  logic emul_r;
  logic [2:0] evt_r;
  logic [2:0] imask_r;
  logic take_req;
  logic done_p;
  logic refused_p;
  logic flag_now;

  // The take bit is a pulse; it is never stored, so a read cannot show it.
  // The same write also carries the emulation enable.
  assign take_req = reg_wr && (reg_addr == GAEA_OFF_CTRL) && reg_wdata[GAEA_CTRL_TAKE];

  // Reserved arm bits are dropped on write, so a read shows only used bits.
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      arm_r <= GAEA_ARM_RST;
    else if (reg_wr && reg_addr == GAEA_OFF_ARM)
      arm_r <= reg_wdata & GAEA_ARM_USED;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      emul_r <= GAEA_EMUL_RST;
    else if (reg_wr && reg_addr == GAEA_OFF_CTRL)
      emul_r <= reg_wdata[GAEA_CTRL_EMUL];
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      imask_r <= GAEA_IMASK_RST;
    else if (reg_wr && reg_addr == GAEA_OFF_IMASK)
      imask_r <= reg_wdata[2:0];
  end

  // ----------------------------------------------------------------
  // Event conditions
  // ----------------------------------------------------------------
  logic ev_gain, ev_per, ev_trg, ev_svc, ev_clr, ev_lsn, ev_tlk, ev_idle;
  logic role_ok;
  logic [15:0] arm_eff;
  logic [7:0] hit;

  // Role bits report a change only when the status byte shows one.
  // A role edge whose change bit comes a cycle later is not counted,
  // so the bus side must present both in the same cycle.
  assign role_ok = chg_s;
  // Control gained and control passed are the controller-side edges.
  assign ev_gain = role_ok && gain_s && !gain_p;
  assign ev_per = role_ok && !act_s && act_p;
  // Trigger and clear are bus commands and count only as peripheral.
  assign ev_trg = !act_s && trg_s && !trg_p;
  assign ev_clr = !act_s && clr_s && !clr_p;
  assign ev_svc = svc_s && !svc_p;
  // Listen, talk and unaddressed edges count only as peripheral.
  assign ev_lsn = role_ok && !act_s && lsn_s && !lsn_p;
  assign ev_tlk = role_ok && !act_s && tlk_s && !tlk_p;
  assign ev_idle = role_ok && !act_s && !lsn_s && !tlk_s && (lsn_p || tlk_p);

  // The address-change bit widens to all role-change conditions.
  assign arm_eff = arm_r | (arm_r[GAEA_ARM_CHG] ? 16'h00C7 : 16'h0000);

  // Each armed condition has its own bit, which keeps the final OR flat.
  always_comb
  begin
    hit = 8'h00;
    hit[GAEA_ARM_GAIN] = arm_eff[GAEA_ARM_GAIN] && ev_gain;
    hit[GAEA_ARM_PER] = arm_eff[GAEA_ARM_PER] && ev_per;
    hit[GAEA_ARM_TRIG] = arm_eff[GAEA_ARM_TRIG] && ev_trg;
    hit[GAEA_ARM_SVC] = arm_eff[GAEA_ARM_SVC] && ev_svc;
    hit[GAEA_ARM_CLR] = arm_eff[GAEA_ARM_CLR] && ev_clr;
    hit[GAEA_ARM_LSN] = arm_eff[GAEA_ARM_LSN] && ev_lsn;
    hit[GAEA_ARM_TLK] = arm_eff[GAEA_ARM_TLK] && ev_tlk;
    hit[GAEA_ARM_IDLE] = arm_eff[GAEA_ARM_IDLE] && ev_idle;
  end

  // No armed condition can set the flag until emulation is switched on.
  assign flag_now = emul_r && (|hit);

  logic [2:0] evt_set;
  logic [2:0] evt_clr;
  assign evt_set = {refused_p, done_p, flag_now};
  assign evt_clr = (reg_wr && reg_addr == GAEA_OFF_EVT) ? reg_wdata[2:0] : 3'h0;

  // Set wins over a clear in the same cycle so no event is lost.
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      evt_r <= 3'h0;
    else
      evt_r <= (evt_r & ~evt_clr) | evt_set;
  end

  // Both outputs lag the sticky bits by one cycle so they leave a flop.
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      event_flag <= 1'b0;
    else
      event_flag <= evt_r[GAEA_EVT_FLAG];
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      irq <= 1'b0;
    else
      irq <= |(evt_r & imask_r);
  end

  // ----------------------------------------------------------------
  // Take-control sequencer
  // ----------------------------------------------------------------
  gaea_state_t st_r;
  logic [15:0] cnt_r;

  // A refusal only flags the event; nothing on the bus moves.
  // A request while busy is ignored, not refused, so software polls busy.
  assign refused_p = take_req && (st_r == GAEA_IDLE) && !act_s;

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      st_r <= GAEA_IDLE;
      cnt_r <= 16'h0000;
      ifc_out <= 1'b0;
      atn_out <= 1'b0;
      cmd_valid <= 1'b0;
      cmd_byte <= 8'h00;
      done_p <= 1'b0;
    end
    else
    begin
      done_p <= 1'b0;
      unique case (st_r)
        GAEA_IDLE:
        begin
          if (take_req && act_s)
          begin
            if (sys_s)
            begin
              st_r <= GAEA_IFC;
              ifc_out <= 1'b1;
              // Loaded one short, as the zero count is a cycle of its own.
              cnt_r <= GAEA_IFC_CYC - 16'h0001;
            end
            else
            begin
              st_r <= GAEA_ATN;
              atn_out <= 1'b1;
            end
          end
        end
        GAEA_IFC:
        begin
          if (cnt_r == 16'h0000)
          begin
            ifc_out <= 1'b0;
            st_r <= GAEA_IDLE;
            done_p <= 1'b1;
          end
          else
            cnt_r <= cnt_r - 16'h0001;
        end
        GAEA_ATN:
        begin
          // Attention leads the first byte by one cycle so it settles first.
          cmd_valid <= 1'b1;
          cmd_byte <= GAEA_CMD_UNT;
          st_r <= GAEA_UNT;
        end
        // A byte is held until the transmitter takes it; a slow instrument
        // only stretches the phase.
        GAEA_UNT:
        begin
          if (cmd_ready)
          begin
            cmd_byte <= GAEA_CMD_UNL;
            st_r <= GAEA_UNL;
          end
        end
        GAEA_UNL:
        begin
          if (cmd_ready)
          begin
            cmd_valid <= 1'b0;
            st_r <= GAEA_IDLE;
            done_p <= 1'b1;
          end
        end
        default:
          st_r <= GAEA_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Read data stand for one cycle only and return to zero afterwards.
  // Unmapped offsets read as zero.
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        GAEA_OFF_CTRL: reg_rdata <= {14'h0000, emul_r, st_r != GAEA_IDLE};
        GAEA_OFF_ARM: reg_rdata <= arm_r;
        GAEA_OFF_STATUS: reg_rdata <= {7'h00, s2_r};
        GAEA_OFF_EVT: reg_rdata <= {13'h0000, evt_r};
        GAEA_OFF_IMASK: reg_rdata <= {13'h0000, imask_r};
        default: reg_rdata <= 16'h0000;
      endcase
    end
    else
      reg_rdata <= 16'h0000;
  end

endmodule : gaea_top

// ---- shared/gaea_pkg.sv ----
package gaea_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] GAEA_OFF_CTRL = 4'h0;
  localparam logic [3:0] GAEA_OFF_ARM = 4'h1;
  localparam logic [3:0] GAEA_OFF_STATUS = 4'h2;
  localparam logic [3:0] GAEA_OFF_EVT = 4'h3;
  localparam logic [3:0] GAEA_OFF_IMASK = 4'h4;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int GAEA_CTRL_TAKE = 0;
  localparam int GAEA_CTRL_EMUL = 1;
  localparam int GAEA_ARM_CHG = 8;
  localparam int GAEA_ARM_GAIN = 7;
  localparam int GAEA_ARM_PER = 6;
  localparam int GAEA_ARM_TRIG = 5;
  localparam int GAEA_ARM_SVC = 4;
  localparam int GAEA_ARM_CLR = 3;
  localparam int GAEA_ARM_LSN = 2;
  localparam int GAEA_ARM_TLK = 1;
  localparam int GAEA_ARM_IDLE = 0;
  localparam logic [15:0] GAEA_ARM_USED = 16'h01FF;
  localparam int GAEA_EVT_FLAG = 0;
  localparam int GAEA_EVT_DONE = 1;
  localparam int GAEA_EVT_REFUSED = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] GAEA_ARM_RST = 16'h0000;
  localparam logic [2:0] GAEA_IMASK_RST = 3'h0;
  localparam logic GAEA_EMUL_RST = 1'b0;

  // ----------------------------------------------------------------
  // Bus bytes and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] GAEA_CMD_UNL = 8'h3F;
  localparam logic [7:0] GAEA_CMD_UNT = 8'h5F;
  localparam int GAEA_CLK_MHZ = 250;
  localparam int GAEA_IFC_US = 100;
  localparam logic [15:0] GAEA_IFC_CYC = 16'(GAEA_IFC_US * GAEA_CLK_MHZ);

  typedef enum logic [2:0] {
    GAEA_IDLE = 3'b000,
    GAEA_IFC = 3'b001,
    GAEA_ATN = 3'b010,
    GAEA_UNT = 3'b011,
    GAEA_UNL = 3'b100
  } gaea_state_t;

endpackage : gaea_pkg

// ---- tb/gaea_checker.sv ----
`timescale 1ns/1ns
module gaea_checker (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic active_ctrl,
  input wire logic system_ctrl,
  input wire logic cmd_ready,
  input wire logic ifc_out,
  input wire logic atn_out,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic event_flag
);
  import gaea_pkg::*;
  logic [15:0] ifc_cnt_r;
  // ------------------------------------------------------------
  // Pulse length of the interface clear.
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || !ifc_out)
      ifc_cnt_r <= 16'h0000;
    else
      ifc_cnt_r <= ifc_cnt_r + 16'h0001;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence s_unt; cmd_valid && cmd_byte == GAEA_CMD_UNT; endsequence
  sequence s_unl; cmd_valid && cmd_byte == GAEA_CMD_UNL; endsequence
  property p_sys; $rose(ifc_out) |-> active_ctrl && system_ctrl; endproperty
  property p_nsys; $rose(atn_out) |-> active_ctrl && !system_ctrl; endproperty
  property p_first; $rose(atn_out) |=> s_unt; endproperty
  property p_unt; s_unt ##0 cmd_ready |=> s_unl; endproperty
  property p_unl; s_unl ##0 cmd_ready |=> !cmd_valid; endproperty
  property p_hold; cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_byte); endproperty
  property p_ifc; $fell(ifc_out) |-> ifc_cnt_r == GAEA_IFC_CYC; endproperty
  property p_arm; reg_rd && reg_addr == GAEA_OFF_ARM |=> reg_rdata[15:9] == 7'h00; endproperty
  property p_rst; $fell(sys_rst) |-> !event_flag; endproperty
  a_sys: assert property (p_sys)
    else $error("ifc outside system control");
  a_nsys: assert property (p_nsys)
    else $error("atn outside plain control");
  a_first: assert property (p_first)
    else $error("untalk not first");
  a_unt: assert property (p_unt)
    else $error("unlisten not after untalk");
  a_unl: assert property (p_unl)
    else $error("command not ended");
  a_hold: assert property (p_hold)
    else $error("command byte not held");
  a_ifc: assert property (p_ifc)
    else $error("ifc pulse length wrong");
  a_arm: assert property (p_arm)
    else $error("reserved arm bits set");
  a_rst: assert property (p_rst)
    else $error("flag set after reset");
endmodule : gaea_checker
bind gaea_top gaea_checker i_chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .active_ctrl(active_ctrl), .system_ctrl(system_ctrl), .cmd_ready(cmd_ready),
  .ifc_out(ifc_out), .atn_out(atn_out), .cmd_valid(cmd_valid),
  .cmd_byte(cmd_byte), .event_flag(event_flag));

// ---- tb/gaea_partner.sv ----
`timescale 1ns/1ns
module gaea_partner (
  input wire logic ref_clk,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic [3:0] stall,
  output logic cmd_ready,
  output logic [15:0] rx_log_r
);
  logic [3:0] wait_r;
  initial cmd_ready = 1'b0;
  initial rx_log_r = 16'h0000;
  // A slow instrument makes the block hold each byte for several cycles.
  always @(posedge ref_clk)
  begin
    if (!cmd_valid || cmd_ready)
    begin
      cmd_ready <= 1'b0;
      wait_r <= stall;
    end
    else if (wait_r == 4'h0)
      cmd_ready <= 1'b1;
    else
      wait_r <= wait_r - 4'h1;
    if (cmd_valid && cmd_ready)
      rx_log_r <= {rx_log_r[7:0], cmd_byte};
  end
endmodule : gaea_partner

// ---- tb/tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
  import gaea_pkg::*;
  logic ref_clk, sys_rst, reg_wr, reg_rd, cmd_ready, ifc_out, atn_out;
  logic cmd_valid, event_flag, irq, f;
  logic [3:0] reg_addr, stall;
  logic [15:0] reg_wdata, reg_rdata, rx_log, lfsr_r, v, a;
  logic [7:0] cmd_byte;
  logic [8:0] ev, nev;
  int bad_count, tests_run, n;
  always #2 ref_clk = ~ref_clk;
  gaea_top i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .active_ctrl(ev[8]), .system_ctrl(ev[7]), .control_gained(ev[6]),
    .listen_selected(ev[5]), .output_role_assigned(ev[4]), .trigger_received(ev[3]),
    .clear_received(ev[2]), .internal_service_request(ev[1]),
    .address_role_changed(ev[0]), .cmd_ready(cmd_ready), .ifc_out(ifc_out),
    .atn_out(atn_out), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
    .event_flag(event_flag), .irq(irq));
  gaea_partner i_far (.ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
    .stall(stall), .cmd_ready(cmd_ready), .rx_log_r(rx_log));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  // Role edges count only while the change bit is high in the same cycle.
  function automatic logic flag_exp(input logic [15:0] m, input logic [8:0] o,
    input logic [8:0] n);
    logic [8:0] r;
    r = n & ~o;
    return n[0] & ((m[7] | m[8]) & r[6] | (m[6] | m[8]) & o[8] & !n[8]
      | !n[8] & ((m[2] | m[8]) & r[5] | (m[1] | m[8]) & r[4]
      | (m[0] | m[8]) & (o[5] | o[4]) & !n[5] & !n[4]))
      | !n[8] & (m[5] & r[3] | m[3] & r[2]) | m[4] & r[1];
  endfunction : flag_exp
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] ad, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] ad);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  task automatic settle();
    repeat (6) @(posedge ref_clk);
  endtask : settle
  task automatic results();
    $display("counts run=%0d bad=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    bad_count++;
    results();
  end
  initial
  begin
    ref_clk = 1'b0;
    sys_rst = 1'b1;
    {reg_wr, reg_rd, reg_addr, reg_wdata, ev, stall} = '0;
    {bad_count, tests_run} = '0;
    lfsr_r = 16'hDF79;
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(GAEA_OFF_ARM);
    chk(v, GAEA_ARM_RST);
    rd(4'hF);
    chk(v, 16'h0000);
    wr(GAEA_OFF_ARM, 16'h0010);
    ev <= 9'h002;
    settle();
    chk(event_flag, 1'b0);
    $display("test reset done");
    wr(GAEA_OFF_CTRL, 16'h0002);
    for (n = 0; n < 48; n++)
    begin
      lfsr_r = lfsr(lfsr_r);
      a = lfsr_r;
      wr(GAEA_OFF_ARM, a);
      rd(GAEA_OFF_ARM);
      chk(v, a & GAEA_ARM_USED);
      wr(GAEA_OFF_IMASK, {15'h0000, a[15]});
      wr(GAEA_OFF_EVT, 16'h0007);
      lfsr_r = lfsr(lfsr_r);
      nev = lfsr_r[8:0];
      f = flag_exp(a, ev, nev);
      ev <= nev;
      settle();
      chk(event_flag, f);
      chk(irq, f & a[15]);
      rd(GAEA_OFF_STATUS);
      chk(v, {7'h00, nev});
    end
    $display("test events done");
    wr(GAEA_OFF_ARM, 16'h0000);
    ev <= 9'h000;
    settle();
    wr(GAEA_OFF_EVT, 16'h0007);
    wr(GAEA_OFF_CTRL, 16'h0003);
    settle();
    rd(GAEA_OFF_EVT);
    chk(v & 16'h0006, 16'h0004);
    chk({ifc_out, atn_out}, 2'b00);
    ev <= 9'h100;
    stall <= lfsr_r[3:0];
    settle();
    wr(GAEA_OFF_CTRL, 16'h0003);
    v = 16'h0000;
    for (n = 0; n < 200 && !v[1]; n++)
      rd(GAEA_OFF_EVT);
    chk(rx_log, {GAEA_CMD_UNT, GAEA_CMD_UNL});
    chk({ifc_out, atn_out}, 2'b01);
    $display("test plain take done");
    ev <= 9'h180;
    settle();
    wr(GAEA_OFF_EVT, 16'h0007);
    wr(GAEA_OFF_CTRL, 16'h0003);
    rd(GAEA_OFF_CTRL);
    chk(v, 16'h0003);
    chk(ifc_out, 1'b1);
    for (n = 0; n < 30000 && ifc_out === 1'b1; n++)
      @(posedge ref_clk);
    settle();
    rd(GAEA_OFF_EVT);
    chk(v & 16'h0006, 16'h0002);
    $display("test system take done");
    results();
  end
endmodule : tb_top
